// file: design/mem_pins.sv
// Memory pin block: boot ROM strobes, SDRAM pin sequencer and reset strap capture, APB registers.
// Assumes pclk at 50 MHz; processor reset, address and parity pins arrive asynchronously.
//
// Behaviour
// (R01) ROM select low for the whole ROM access, high otherwise.
// (R02) In ROM cycles address bit 31 is write enable, bit 30 output enable.
// (R03) In ROM cycles address bits 29:28 carry the two low ROM address bits.
// (R04) Row then column address are multiplexed onto the thirteen address lines.
// (R05) Two bank select outputs pick the SDRAM internal bank.
// (R06) Three op lines carry row strobe, column strobe and write enable.
// (R07) Four byte strobes mask writes, line n covering data byte n.
// (R08) Four active-low array selects choose one SDRAM array.
// (R09) Buffer direction output is low during SDRAM writes.
// (R10) With parity enabled, one parity bit per data byte on four lines.
// (R11) Four array clocks, one per array, reference SDRAM pin timing.
// (R12) Address pins are inputs during processor reset, latched at its release.
// (R13) Unterminated strap pins read 1; board pulls down for 0.
// (R14) Strap bit 8 at 1 is normal, 0 enables vendor test mode.
// (R15) Strap bit 7 at 0 selects PCI arbiter, 1 the parallel port.
// (R16) Strap bit 6 at 1 refuses PCI until processor initializes registers.
// (R17) Strap bit 6 at 0 allows PCI before initialization.
// (R18) Strap bits 5:4 set ROM width: 11 byte, 01 word, 10 dword.
// (R19) Class code reads B40001h with strap bit 3 at 1, else 0E0001h.
// (R20) Strap bit 2 at 1 is normal, 0 enables output-hold test mode.
// (R21) Latched straps stay constant until the next processor reset; presetn also reloads 7Fh and recaptures them at its release.
`timescale 1ns/10ps

module mem_pins (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic processor_reset_n,
	output logic rom_select_n,
	input wire logic [3:0] rom_addr_hi_in,
	output logic [3:0] rom_addr_hi_out,
	output logic rom_addr_hi_oe,
	input wire logic [12:0] mux_addr_lines_in,
	output logic [12:0] mux_addr_lines_out,
	output logic mux_addr_lines_oe,
	output logic [1:0] sdram_quadrant_sel,
	output logic [2:0] sdram_op_lines,
	output logic [3:0] byte_write_strobe_n,
	output logic [3:0] array_select_n,
	output logic sdram_buffer_dir_n,
	input wire logic [3:0] parity_in,
	output logic [3:0] parity_out,
	output logic parity_oe,
	output logic [3:0] array_clock_out,
	output logic mfg_test_mode,
	output logic ohold_test_mode,
	output logic pci_arbiter_sel,
	output logic pci_access_allowed,
	output logic [1:0] rom_width_sel,
	output logic [23:0] class_code
);
	typedef struct packed {
		mem_pins_pkg::seq_e st;
		logic col;
		logic [7:0] cnt;
		logic sdclk;
		logic rom_go;
		logic sd_go;
		logic par_en;
		logic csr_done;
		logic [2:0] rom_cmd;
		logic [29:0] sd_addr;
		logic [31:0] sd_data;
		logic [4:0] sd_go_reg;
		logic rst_s1;
		logic rst_s2;
		logic rst_q;
		logic [12:0] ma_s1;
		logic [12:0] ma_s2;
		logic [3:0] par_s1;
		logic [3:0] par_s2;
		logic [6:0] straps;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic rom_select_n;
		logic [3:0] a_hi;
		logic a_hi_oe;
		logic [12:0] ma_o;
		logic ma_oe;
		logic [1:0] ba;
		logic [2:0] cmd;
		logic [3:0] dqm;
		logic [3:0] cs_n;
		logic dir_n;
		logic [3:0] par_o;
		logic par_oe;
		logic [23:0] class_code;
		// Strap decodes held in flops so every output leaves a register
		logic mfg;
		logic ohold;
		logic arb;
		logic pci_ok;
		logic [1:0] width;
	} state_s;

	state_s s;
	state_s next_s;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [3:0] byte_parity(input logic [31:0] d);
		logic [3:0] p;
		p = '0;
		for (int i = 0; i < 4; i++) begin
			p[i] = ^d[8*i +: 8];
		end
		return p;
	endfunction : byte_parity

	function automatic logic [3:0] one_cold(input logic [1:0] n);
		logic [3:0] v;
		v = 4'hf;
		v[n] = 1'b0;
		return v;
	endfunction : one_cold

	// Strap vector starts at the lowest strap pin
	function automatic logic strap_bit(input logic [6:0] straps, input int pos);
		return straps[pos - mem_pins_pkg::STRAP_OHOLD];
	endfunction : strap_bit

	// ROM counter is eight bits wide; longer access times need a wider count
	if (mem_pins_pkg::ROM_CYC < 1 || mem_pins_pkg::ROM_CYC > 256) begin : g_rom_cyc_check
		$error("ROM cycle count does not fit the eight-bit counter");
	end

	logic unused_a_hi;
	assign unused_a_hi = ^rom_addr_hi_in;

	always_comb begin
		logic busy;
		logic ce;
		logic wr_hit;
		logic [6:0] st_v;
		busy = 1'b0;
		ce = 1'b0;
		wr_hit = 1'b0;
		st_v = '0;
		next_s = s;

		// ----------------------------------------------------------------
		// Synchronisers
		// ----------------------------------------------------------------
		next_s.rst_s1 = processor_reset_n;
		next_s.rst_s2 = s.rst_s1;
		next_s.rst_q = s.rst_s2;
		next_s.ma_s1 = mux_addr_lines_in;
		next_s.ma_s2 = s.ma_s1;
		next_s.par_s1 = parity_in;
		next_s.par_s2 = s.par_s1;

		// ----------------------------------------------------------------
		// Straps
		// ----------------------------------------------------------------
		// Capture on the synchronised release edge; pins released during reset
		if (s.rst_s2 && !s.rst_q) begin
			next_s.straps = s.ma_s2[8:2]; // R12 R13
		end
		st_v = next_s.straps; // R21
		next_s.class_code = strap_bit(st_v, mem_pins_pkg::STRAP_CLASS) ? mem_pins_pkg::CLASS_ONE
			: mem_pins_pkg::CLASS_ZERO; // R19
		// Decodes follow the next strap value so they move on the capture edge
		next_s.mfg = ~strap_bit(st_v, mem_pins_pkg::STRAP_TEST); // R14
		next_s.ohold = ~strap_bit(st_v, mem_pins_pkg::STRAP_OHOLD); // R20
		next_s.arb = ~strap_bit(st_v, mem_pins_pkg::STRAP_XBUS); // R15
		next_s.width = st_v[mem_pins_pkg::STRAP_WIDTH - mem_pins_pkg::STRAP_OHOLD +: 2]; // R18

		// ----------------------------------------------------------------
		// Sequencer
		// ----------------------------------------------------------------
		// Array clocks run at half pclk; SDRAM pins change at their falling edge, ROM pins on any pclk edge
		next_s.sdclk = ~s.sdclk; // R11
		ce = s.sdclk;
		busy = (s.st != mem_pins_pkg::ST_IDLE) || s.rom_go || s.sd_go;
		unique case (s.st)
			mem_pins_pkg::ST_IDLE: begin
				if (s.rom_go && s.rst_s2) begin
					next_s.rom_go = 1'b0;
					next_s.st = mem_pins_pkg::ST_ROM;
					next_s.cnt = mem_pins_pkg::ROM_CYC_M1;
					next_s.rom_select_n = 1'b0; // R01
					next_s.a_hi_oe = 1'b1;
					next_s.a_hi = {~s.rom_cmd[mem_pins_pkg::ROM_WR], s.rom_cmd[mem_pins_pkg::ROM_WR],
						s.rom_cmd[1:0]}; // R02 R03
				end else if (s.sd_go && s.rst_s2 && ce) begin
					next_s.sd_go = 1'b0;
					next_s.st = mem_pins_pkg::ST_SDROW;
					next_s.col = 1'b0;
					next_s.ma_o = s.sd_addr[12:0]; // R04
					next_s.ba = s.sd_addr[mem_pins_pkg::SDA_BANK +: 2]; // R05
					next_s.cs_n = one_cold(s.sd_addr[mem_pins_pkg::SDA_ARR +: 2]); // R08
					next_s.cmd = mem_pins_pkg::CMD_ACT; // R06
				end
			end
			mem_pins_pkg::ST_ROM: begin
				if (s.cnt == 8'h00) begin
					next_s.st = mem_pins_pkg::ST_IDLE;
					next_s.rom_select_n = 1'b1; // R01
					next_s.a_hi_oe = 1'b0;
					next_s.a_hi = 4'hf;
				end else begin
					next_s.cnt = s.cnt - 8'h01;
				end
			end
			mem_pins_pkg::ST_SDROW: begin
				if (ce && !s.col) begin
					next_s.col = 1'b1;
					next_s.ma_o = s.sd_addr[mem_pins_pkg::SDA_COL +: 13]; // R04
					next_s.cmd = s.sd_go_reg[0] ? mem_pins_pkg::CMD_WR : mem_pins_pkg::CMD_RD; // R06
					next_s.dqm = s.sd_go_reg[mem_pins_pkg::SDG_MASK +: 4]; // R07
					next_s.dir_n = ~s.sd_go_reg[0]; // R09
					next_s.par_o = byte_parity(s.sd_data); // R10
					next_s.par_oe = s.sd_go_reg[0] && s.par_en; // R10
				end else if (ce) begin
					next_s.st = mem_pins_pkg::ST_IDLE;
					next_s.col = 1'b0;
					next_s.cmd = mem_pins_pkg::CMD_NOP;
					next_s.cs_n = 4'hf;
					next_s.dqm = 4'hf;
					next_s.dir_n = 1'b1;
					next_s.par_oe = 1'b0;
				end
			end
		endcase
		// Address pins float while the processor is held in reset
		// Only the second synchroniser flop may feed logic
		next_s.ma_oe = s.rst_s2; // R12

		// ----------------------------------------------------------------
		// APB slave, one wait state
		// ----------------------------------------------------------------
		next_s.pready = 1'b0;
		if (psel && penable && !s.pready) begin
			next_s.pready = 1'b1;
			next_s.pslverr = 1'b0;
			next_s.prdata = '0;
			unique case (paddr)
				mem_pins_pkg::OFS_CTRL: next_s.prdata = {30'h0, s.csr_done, s.par_en};
				mem_pins_pkg::OFS_ROM: next_s.prdata = {29'h0, s.rom_cmd};
				mem_pins_pkg::OFS_SD_ADDR: next_s.prdata = {2'h0, s.sd_addr};
				mem_pins_pkg::OFS_SD_DATA: next_s.prdata = s.sd_data;
				mem_pins_pkg::OFS_SD_GO: next_s.prdata = {27'h0, s.sd_go_reg};
				mem_pins_pkg::OFS_STATUS: begin
					next_s.prdata = {16'h0, s.par_s2, s.width, s.pci_ok, s.straps, 1'b0, busy};
				end
				mem_pins_pkg::OFS_CLASS: next_s.prdata = {8'h00, s.class_code}; // R19
				default: next_s.pslverr = 1'b1;
			endcase
		end
		wr_hit = psel && penable && s.pready && pwrite;
		if (wr_hit) begin
			unique case (paddr)
				mem_pins_pkg::OFS_CTRL: begin
					next_s.par_en = pwdata[mem_pins_pkg::CTRL_PAR_EN];
					next_s.csr_done = pwdata[mem_pins_pkg::CTRL_CSR_DONE];
				end
				mem_pins_pkg::OFS_ROM: begin
					// Starts ignored while a cycle is pending or running
					if (!busy) begin
						next_s.rom_cmd = pwdata[2:0];
						next_s.rom_go = 1'b1;
					end
				end
				mem_pins_pkg::OFS_SD_ADDR: next_s.sd_addr = pwdata[29:0];
				mem_pins_pkg::OFS_SD_DATA: next_s.sd_data = pwdata;
				mem_pins_pkg::OFS_SD_GO: begin
					if (!busy) begin
						next_s.sd_go_reg = pwdata[4:0];
						next_s.sd_go = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
		// Blank ROM strap opens PCI before initialization
		next_s.pci_ok = ~strap_bit(st_v, mem_pins_pkg::STRAP_BLANK) | next_s.csr_done; // R16 R17
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.st <= mem_pins_pkg::ST_IDLE;
			s.straps <= mem_pins_pkg::STRAP_RST; // R13
			s.class_code <= mem_pins_pkg::CLASS_ONE;
			s.rom_select_n <= 1'b1;
			s.a_hi <= 4'hf;
			s.cmd <= mem_pins_pkg::CMD_NOP;
			s.dqm <= 4'hf;
			s.cs_n <= 4'hf;
			s.dir_n <= 1'b1;
			s.width <= mem_pins_pkg::STRAP_RST[mem_pins_pkg::STRAP_WIDTH - mem_pins_pkg::STRAP_OHOLD +: 2];
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign rom_select_n = s.rom_select_n;
	assign rom_addr_hi_out = s.a_hi;
	assign rom_addr_hi_oe = s.a_hi_oe;
	assign mux_addr_lines_out = s.ma_o;
	assign mux_addr_lines_oe = s.ma_oe;
	assign sdram_quadrant_sel = s.ba;
	assign sdram_op_lines = s.cmd;
	assign byte_write_strobe_n = s.dqm;
	assign array_select_n = s.cs_n;
	assign sdram_buffer_dir_n = s.dir_n;
	assign parity_out = s.par_o;
	assign parity_oe = s.par_oe;
	assign array_clock_out = {4{s.sdclk}}; // R11
	assign mfg_test_mode = s.mfg; // R14
	assign ohold_test_mode = s.ohold; // R20
	assign pci_arbiter_sel = s.arb; // R15
	assign pci_access_allowed = s.pci_ok; // R16 R17
	assign rom_width_sel = s.width; // R18
	assign class_code = s.class_code;
endmodule : mem_pins

// file: shared/mem_pins_pkg.sv
// Package for the memory pin block: register map, field positions, reset values, timing, state.
// Assumes a 50 MHz APB clock and a single clock domain.
package mem_pins_pkg;
	// Timing
	localparam int CLK_NS = 20;
	localparam int ROM_ACCESS_NS = 200;
	localparam int ROM_CYC = (ROM_ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] ROM_CYC_M1 = 8'(ROM_CYC - 1);
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ROM = 8'h04;
	localparam logic [7:0] OFS_SD_ADDR = 8'h08;
	localparam logic [7:0] OFS_SD_DATA = 8'h0c;
	localparam logic [7:0] OFS_SD_GO = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_CLASS = 8'h18;
	// Field positions
	localparam int CTRL_PAR_EN = 0;
	localparam int CTRL_CSR_DONE = 1;
	localparam int ROM_WR = 2;
	localparam int SDA_COL = 13;
	localparam int SDA_BANK = 26;
	localparam int SDA_ARR = 28;
	localparam int SDG_MASK = 1;
	localparam int ST_STRAP = 2;
	localparam int ST_PCI_OK = 9;
	localparam int ST_WIDTH = 10;
	localparam int ST_PAR_IN = 12;
	// Strap bit positions on the multiplexed address pins
	localparam int STRAP_OHOLD = 2;
	localparam int STRAP_CLASS = 3;
	localparam int STRAP_WIDTH = 4;
	localparam int STRAP_BLANK = 6;
	localparam int STRAP_XBUS = 7;
	localparam int STRAP_TEST = 8;
	// Reset values and encodings
	localparam logic [6:0] STRAP_RST = 7'h7f;
	localparam logic [23:0] CLASS_ONE = 24'hb4_0001;
	localparam logic [23:0] CLASS_ZERO = 24'h0e_0001;
	localparam logic [2:0] CMD_NOP = 3'h7;
	localparam logic [2:0] CMD_ACT = 3'h3;
	localparam logic [2:0] CMD_RD = 3'h5;
	localparam logic [2:0] CMD_WR = 3'h4;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ROM = 3'b010,
		ST_SDROW = 3'b100
	} seq_e;
endpackage : mem_pins_pkg

// file: testbench/mem_board.sv
// Board model: strap resistors, undriven address and parity pins.
// Assumes the block drives the pins only while its enables are high.
`timescale 1ns/10ps
module mem_board (
	input wire logic [12:0] mux_addr_lines_out,
	input wire logic mux_addr_lines_oe,
	input wire logic [3:0] rom_addr_hi_out,
	input wire logic rom_addr_hi_oe,
	input wire logic [3:0] parity_out,
	input wire logic parity_oe,
	input wire logic [6:0] strap_pd,
	output logic [12:0] mux_addr_lines_in,
	output logic [3:0] rom_addr_hi_in,
	output logic [3:0] parity_in
);
	logic [12:0] last = 13'h0000;
	always @(mux_addr_lines_out or mux_addr_lines_oe)
		if (mux_addr_lines_oe) last = mux_addr_lines_out;
	// Pull-ups win unless pulled down; other bits float, so show the inverse
	assign mux_addr_lines_in = mux_addr_lines_oe ? mux_addr_lines_out : {~last[12:9], ~strap_pd, ~last[1:0]};
	assign rom_addr_hi_in = rom_addr_hi_oe ? rom_addr_hi_out : ~rom_addr_hi_out;
	assign parity_in = parity_oe ? parity_out : 4'h0;
endmodule : mem_board

// file: testbench/mem_pins_monitor.sv
// Checker for the memory pin block, watching only its top-level ports.
// Assumes one pclk domain with asynchronous active-low presetn.
`timescale 1ns/10ps
module mem_pins_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic processor_reset_n,
	input wire logic rom_select_n,
	input wire logic [3:0] rom_addr_hi_out,
	input wire logic rom_addr_hi_oe,
	input wire logic mux_addr_lines_oe,
	input wire logic [2:0] sdram_op_lines,
	input wire logic [3:0] byte_write_strobe_n,
	input wire logic [3:0] array_select_n,
	input wire logic sdram_buffer_dir_n,
	input wire logic parity_oe,
	input wire logic [3:0] array_clock_out,
	input wire logic [23:0] class_code
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rom_len;
		$fell(rom_select_n) |-> (!rom_select_n)[*8] ##1 (!rom_select_n)[*2] ##1 rom_select_n;
	endproperty
	a_rom_len: assert property (p_rom_len) else $error("rom select not low for ten cycles");
	property p_rom_pins;
		(rom_addr_hi_oe == !rom_select_n) && (rom_select_n || (rom_addr_hi_out[3] ^ rom_addr_hi_out[2]));
	endproperty
	a_rom_pins: assert property (p_rom_pins) else $error("rom enables wrong");
	property p_act;
		$rose(sdram_op_lines == mem_pins_pkg::CMD_ACT) |-> $onehot(~array_select_n) ##1
			sdram_op_lines == mem_pins_pkg::CMD_ACT ##1
			(sdram_op_lines == mem_pins_pkg::CMD_RD || sdram_op_lines == mem_pins_pkg::CMD_WR);
	endproperty
	a_act: assert property (p_act) else $error("activate phase wrong");
	property p_idle;
		sdram_op_lines == mem_pins_pkg::CMD_NOP |-> array_select_n == 4'hf && byte_write_strobe_n == 4'hf;
	endproperty
	a_idle: assert property (p_idle) else $error("idle selects or masks active");
	property p_dir;
		(sdram_buffer_dir_n == (sdram_op_lines != mem_pins_pkg::CMD_WR)) &&
			(!parity_oe || sdram_op_lines == mem_pins_pkg::CMD_WR);
	endproperty
	a_dir: assert property (p_dir) else $error("buffer direction or parity enable wrong");
	property p_clk;
		1'b1 |=> (&array_clock_out || !(|array_clock_out)) && array_clock_out != $past(array_clock_out);
	endproperty
	a_clk: assert property (p_clk) else $error("array clocks not toggling together");
	property p_phase;
		$changed(sdram_op_lines) |-> array_clock_out == 4'h0;
	endproperty
	a_phase: assert property (p_phase) else $error("command changed off clock fall");
	property p_strap_oe;
		(!processor_reset_n)[*4] |-> !mux_addr_lines_oe;
	endproperty
	a_strap_oe: assert property (p_strap_oe) else $error("address lines driven in reset");
	property p_strap_hold;
		processor_reset_n[*5] |-> $stable(class_code) &&
			(class_code == mem_pins_pkg::CLASS_ONE || class_code == mem_pins_pkg::CLASS_ZERO);
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("class code moved");
endmodule : mem_pins_monitor

bind mem_pins mem_pins_monitor mem_pins_monitor_inst (.pclk, .presetn, .processor_reset_n, .rom_select_n,
	.rom_addr_hi_out, .rom_addr_hi_oe, .mux_addr_lines_oe, .sdram_op_lines, .byte_write_strobe_n,
	.array_select_n, .sdram_buffer_dir_n, .parity_oe, .array_clock_out, .class_code);

// file: testbench/testbench.sv
// Self-checking bench for the memory pin block over APB.
// Assumes the package offsets and a 50 MHz pclk.
`timescale 1ns/10ps
module testbench;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, processor_reset_n = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic pready, pslverr, rom_select_n, rom_addr_hi_oe, mux_addr_lines_oe, sdram_buffer_dir_n, parity_oe, e;
	logic mfg_test_mode, ohold_test_mode, pci_arbiter_sel, pci_access_allowed;
	logic [3:0] rom_addr_hi_in, rom_addr_hi_out, byte_write_strobe_n, array_select_n, parity_in, parity_out;
	logic [3:0] array_clock_out;
	logic [12:0] mux_addr_lines_in, mux_addr_lines_out;
	logic [1:0] sdram_quadrant_sel, rom_width_sel;
	logic [2:0] sdram_op_lines;
	logic [23:0] class_code;
	logic [6:0] strap_pd = 7'h00, s;
	logic [6:0] pats [4] = '{7'h00, 7'h7f, 7'h55, 7'h2a};
	int errors = 0, tests_run = 0, cyc = 0, n;
	always #10 pclk = ~pclk;
	mem_pins mem_pins_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .processor_reset_n, .rom_select_n, .rom_addr_hi_in, .rom_addr_hi_out, .rom_addr_hi_oe,
		.mux_addr_lines_in, .mux_addr_lines_out, .mux_addr_lines_oe, .sdram_quadrant_sel, .sdram_op_lines,
		.byte_write_strobe_n, .array_select_n, .sdram_buffer_dir_n, .parity_in, .parity_out, .parity_oe,
		.array_clock_out, .mfg_test_mode, .ohold_test_mode, .pci_arbiter_sel, .pci_access_allowed,
		.rom_width_sel, .class_code);
	mem_board mem_board_inst (.mux_addr_lines_out, .mux_addr_lines_oe, .rom_addr_hi_out, .rom_addr_hi_oe,
		.parity_out, .parity_oe, .strap_pd, .mux_addr_lines_in, .rom_addr_hi_in, .parity_in);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic conclude;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Entered just after a rising edge; idles one cycle after so psel never gets two updates at once
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) errors++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer
	task automatic op_wait(input logic [2:0] c);
		n = 0;
		while (sdram_op_lines !== c && n < 50) begin
			@(negedge pclk);
			n++;
		end
	endtask : op_wait
	task automatic straps(input logic [6:0] pd);
		s = ~pd;
		strap_pd <= pd;
		processor_reset_n <= 1'b0;
		repeat (6) @(posedge pclk);
		processor_reset_n <= 1'b1;
		repeat (6) @(posedge pclk);
		strap_pd <= ~pd;
		xfer(1'b0, mem_pins_pkg::OFS_STATUS, 32'h0000_0000);
		chk(32'(q[8:2]), 32'(s));
		chk(32'({mfg_test_mode, ohold_test_mode, pci_arbiter_sel, pci_access_allowed, rom_width_sel, class_code}),
			32'({~s[6], ~s[0], ~s[5], ~s[4], s[3:2], s[1] ? mem_pins_pkg::CLASS_ONE : mem_pins_pkg::CLASS_ZERO}));
	endtask : straps
	task automatic rom(input logic [31:0] d, input logic [3:0] pins);
		xfer(1'b1, mem_pins_pkg::OFS_ROM, d);
		op_wait(mem_pins_pkg::CMD_NOP);
		n = 0;
		while (rom_select_n !== 1'b0 && n < 20) begin
			@(negedge pclk);
			n++;
		end
		chk(32'({rom_addr_hi_oe, rom_addr_hi_out}), 32'({1'b1, pins}));
		n = 0;
		while (rom_select_n === 1'b0 && n < 30) begin
			@(negedge pclk);
			n++;
		end
		chk(32'(n), 32'(mem_pins_pkg::ROM_CYC));
		@(posedge pclk);
	endtask : rom
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			conclude;
		end
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		xfer(1'b0, mem_pins_pkg::OFS_CLASS, 32'h0000_0000);
		chk(q, 32'(mem_pins_pkg::CLASS_ONE));
		for (int i = 0; i < 4; i++) straps(pats[i]);
		xfer(1'b1, mem_pins_pkg::OFS_CTRL, 32'h0000_0003);
		chk(32'(pci_access_allowed), 32'h0000_0001);
		rom(32'h0000_0006, 4'h6);
		rom(32'h0000_0001, 4'h9);
		xfer(1'b1, mem_pins_pkg::OFS_SD_ADDR, {4'h9, 2'b01, 13'h0abc, 13'h1234});
		xfer(1'b1, mem_pins_pkg::OFS_SD_DATA, 32'h0100_ff07);
		xfer(1'b1, mem_pins_pkg::OFS_SD_GO, 32'h0000_000b);
		op_wait(mem_pins_pkg::CMD_ACT);
		chk(32'({mux_addr_lines_out, sdram_quadrant_sel, array_select_n}), 32'({13'h1234, 2'b01, 4'hd}));
		op_wait(mem_pins_pkg::CMD_WR);
		chk(32'({mux_addr_lines_out, byte_write_strobe_n, sdram_buffer_dir_n, parity_out, parity_oe}),
			32'({13'h0abc, 4'h5, 1'b0, 4'h9, 1'b1}));
		@(posedge pclk);
		xfer(1'b1, mem_pins_pkg::OFS_SD_GO, 32'h0000_0000);
		op_wait(mem_pins_pkg::CMD_RD);
		chk(32'({sdram_buffer_dir_n, parity_oe}), 32'h0000_0002);
		@(posedge pclk);
		xfer(1'b0, 8'h1c, 32'h0000_0000);
		chk({q[30:0], e}, 32'h0000_0001);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		xfer(1'b0, mem_pins_pkg::OFS_CLASS, 32'h0000_0000);
		chk(q, 32'(mem_pins_pkg::CLASS_ONE));
		conclude;
	end
endmodule : testbench
